// ==== dv/mrb_host_model.sv ====
// host controller model: mode register commands and burst requests
`timescale 1ns/1ps
module mrb_host_model
  import mrb_pkg::*;
#(
  parameter int COL_W = 10
) (
  // clock
  input wire logic clock,
  // mode register access
  output logic mrRead,
  output logic mrWrite,
  output logic [7:0] mrAddr,
  output logic [7:0] mrWdata,
  input wire logic [7:0] rdData,
  input wire logic rdStrobe,
  // burst requests
  output logic burstReq,
  output logic burstWrite,
  output logic burstAutoPre,
  output logic [COL_W-1:0] burstCol
);
  initial
  begin
    {mrRead, mrWrite, burstReq, burstWrite, burstAutoPre} = 5'h00;
    mrAddr = 8'h00;
    mrWdata = 8'h00;
    burstCol = '0;
  end

  task regWrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    mrWrite = 1'b1;
    mrAddr = a;
    mrWdata = d;
    @(posedge clock);
    #1;
    mrWrite = 1'b0;
    // released lines must not keep the last value
    mrAddr = ~a;
    mrWdata = ~d;
  endtask : regWrite

  task regRead(input logic [7:0] a, output logic [7:0] d, output logic s);
    @(posedge clock);
    #1;
    mrRead = 1'b1;
    mrAddr = a;
    @(posedge clock);
    #1;
    mrRead = 1'b0;
    mrAddr = ~a;
    s = rdStrobe;
    d = rdData;
  endtask : regRead

  task burst(input logic [COL_W-1:0] c, input logic wr, input logic ap);
    @(posedge clock);
    #1;
    burstReq = 1'b1;
    burstCol = c;
    burstWrite = wr;
    burstAutoPre = ap;
    @(posedge clock);
    #1;
    burstReq = 1'b0;
    burstCol = ~c;
  endtask : burst
endmodule : mrb_host_model

// ==== dv/tb_mrb_mode_burst.sv ====
// testbench for the mode register and burst block
`timescale 1ns/1ps
`define CHECK(nm, ex, got) \
  begin \
    nTests++; \
    if ((got) !== (ex)) \
    begin \
      nFail++; \
      $display("BAD %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module tb_mrb_mode_burst
  import mrb_pkg::*;
;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic mrRead, mrWrite, rdStrobe, autoInitDone, calDone, pinTiedSupply, calCmd;
  logic calRun, factoryTrim, burstReq, burstWrite, burstAutoPre;
  logic colValid, prechargeStart, busy;
  logic [7:0] mrAddr, mrWdata, rdData;
  logic [1:0] calResult;
  logic [9:0] burstCol, colOut;
  int nFail = 0;
  int nTests = 0;
  int cycles = 0;
  int nwrNeed = 0;

  always #20 clock = ~clock;

  mrb_mode_burst i_dut (.clock(clock), .nrst(nrst), .mrRead(mrRead), .mrWrite(mrWrite),
    .mrAddr(mrAddr), .mrWdata(mrWdata), .rdData(rdData), .rdStrobe(rdStrobe),
    .autoInitDone(autoInitDone), .calDone(calDone), .calResult(calResult),
    .pinTiedSupply(pinTiedSupply), .calCmd(calCmd), .calRun(calRun),
    .factoryTrim(factoryTrim), .burstReq(burstReq), .burstWrite(burstWrite),
    .burstAutoPre(burstAutoPre), .burstCol(burstCol), .colOut(colOut),
    .colValid(colValid), .prechargeStart(prechargeStart), .busy(busy));

  mrb_host_model i_host (.clock(clock), .mrRead(mrRead), .mrWrite(mrWrite),
    .mrAddr(mrAddr), .mrWdata(mrWdata), .rdData(rdData), .rdStrobe(rdStrobe),
    .burstReq(burstReq), .burstWrite(burstWrite), .burstAutoPre(burstAutoPre),
    .burstCol(burstCol));

  // ***************************************************
  // helpers
  // ***************************************************
  task summarize;
    if (nFail == 0 && nTests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  // a hung handshake ends the run as a failure
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      nFail++;
      summarize();
    end
  end

  function automatic logic [9:0] expCol(input logic [9:0] s, input int i, input int bl,
      input logic il, input logic nw);
    logic [9:0] y;
    logic [3:0] b;
    y = {s[9:1], 1'b0};
    b = 4'(i);
    if (nw)
      return y + {6'h00, b};
    if (bl == 4)
      return {y[9:2], y[1:0] + b[1:0]};
    if (bl == 8)
      return {y[9:3], il ? (y[2:0] ^ b[2:0]) : (y[2:0] + b[2:0])};
    return {y[9:4], y[3:0] + b[3:0]};
  endfunction : expCol

  task checkRead(input logic [7:0] a, input logic [7:0] ex);
    logic [7:0] d;
    logic s;
    i_host.regRead(a, d, s);
    `CHECK("rdStrobe", 1'b1, s)
    `CHECK("rdData", ex, d)
  endtask : checkRead

  // ***************************************************
  // scenarios
  // ***************************************************
  task tInfo;
    checkRead(INFO_REG_ADDR, 8'h01);
    @(posedge clock);
    #1;
    autoInitDone = 1'b1;
    checkRead(INFO_REG_ADDR, 8'h00);
    i_host.regWrite(INFO_REG_ADDR, 8'hFF);
    checkRead(INFO_REG_ADDR, 8'h00);
    checkRead(FEATURE_REG_ADDR, UNDEF_READ_DATA);
  endtask : tInfo

  task calStep(input logic tied, input logic [1:0] res, input logic [7:0] info,
      input logic trim, input logic run);
    @(posedge clock);
    #1;
    pinTiedSupply = tied;
    calResult = res;
    calDone = 1'b1;
    @(posedge clock);
    #1;
    calDone = 1'b0;
    @(posedge clock);
    #1;
    `CHECK("factoryTrim", trim, factoryTrim)
    calCmd = 1'b1;
    @(posedge clock);
    #1;
    calCmd = 1'b0;
    `CHECK("calRun", run, calRun)
    checkRead(INFO_REG_ADDR, info);
  endtask : calStep

  task runBurst(input logic [7:0] feat, input logic [9:0] start, input logic ap,
      input int write_recovery_cycles);
    int bl;
    int k;
    bl = (feat[2:0] == BL_CODE_8) ? 8 : (feat[2:0] == BL_CODE_16) ? 16 : 4;
    // the reset value is never written, so the first burst runs on defaults
    if (feat !== FEATURE_RESET)
      i_host.regWrite(FEATURE_REG_ADDR, feat);
    i_host.burst(start, ap, ap);
    for (int i = 0; i < bl; i++)
    begin
      `CHECK("colValid", 1'b1, colValid)
      `CHECK("busy", 1'b1, busy)
      `CHECK("colOut", expCol(start, i, bl, feat[3], feat[4]), colOut)
      @(posedge clock);
      #1;
    end
    `CHECK("colValid", 1'b0, colValid)
    `CHECK("busy", ap, busy)
    if (ap)
    begin
      k = 0;
      while (prechargeStart !== 1'b1 && k < 20)
      begin
        @(posedge clock);
        #1;
        k++;
      end
      `CHECK("recovery", write_recovery_cycles, k)
      `CHECK("busy", 1'b0, busy)
    end
  endtask : runBurst

  initial
  begin
    {autoInitDone, calDone, pinTiedSupply, calCmd} = 4'h0;
    calResult = 2'h0;
    repeat (6) @(posedge clock);
    #1;
    nrst = 1'b1;
    tInfo();
    calStep(1'b0, 2'h2, 8'h10, 1'b1, 1'b0);
    calStep(1'b1, 2'h3, 8'h08, 1'b1, 1'b0);
    calStep(1'b0, 2'h3, 8'h18, 1'b0, 1'b1);
    runBurst(8'h22, 10'h007, 1'b1, 3);
    runBurst(8'h2B, 10'h00B, 1'b0, 0);
    runBurst(8'h23, 10'h00B, 1'b0, 0);
    runBurst(8'h24, 10'h3FB, 1'b0, 0);
    runBurst(8'h32, 10'h0FE, 1'b0, 0);
    runBurst(8'h42, 10'h3F9, 1'b1, 4);
    // 300 ns of write recovery on a 40 ns clock rounds up to eight cycles
    nwrNeed = (300 + 40 - 1) / 40;
    runBurst({3'(nwrNeed - 2), 5'h12}, 10'h002, 1'b1, nwrNeed);
    summarize();
  end
endmodule : tb_mrb_mode_burst

// ==== hw/mrb_mode_burst.sv ====
// mode register pair, impedance self-test status and burst column sequencer
// ***************************************************
// Summary of operation
// - info bit 0 reads 1 while auto-initialization runs, 0 after
// - info bits 1 and 2 read zero: S4 class, no invalid-data signalling
// - info bits 4:3 hold the impedance pin self-test result code
// - self-test field updates when initialization calibration completes
// - pin tied to command supply makes the self-test field read 01
// - results 01 or 10 force factory trim and ignore calibration commands
// - result 11 only means a resistor is present, value unchecked
// - feature bit 4 picks wrap or no wrap, no wrap with length 4
// - write burst with auto precharge starts precharge after recovery count
// - column bit 0 is forced zero, bursts start on even columns
// - 4-beat wrapped bursts run 0,1,2,3 or 2,3,0,1
// - 8-beat bursts add or xor the beat index in three bits
// - 16-beat bursts are sequential wrapped only
// - 4-beat no-wrap bursts run y to y+3 without wrapping
// - reserved info bits read as zero
// - reading the feature register gives undefined data with strobe
// ***************************************************
`timescale 1ns/1ps
module mrb_mode_burst
  import mrb_pkg::*;
#(
  parameter int COL_W = 10
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // mode register access
  input wire logic mrRead,
  input wire logic mrWrite,
  input wire logic [7:0] mrAddr,
  input wire logic [7:0] mrWdata,
  output logic [7:0] rdData,
  output logic rdStrobe,
  // initialization and impedance calibration
  input wire logic autoInitDone,
  input wire logic calDone,
  input wire logic [1:0] calResult,
  input wire logic pinTiedSupply,
  input wire logic calCmd,
  output logic calRun,
  output logic factoryTrim,
  // burst requests
  input wire logic burstReq,
  input wire logic burstWrite,
  input wire logic burstAutoPre,
  input wire logic [COL_W-1:0] burstCol,
  output logic [COL_W-1:0] colOut,
  output logic colValid,
  output logic prechargeStart,
  output logic busy
);

  // ***************************************************
  // registers
  // ***************************************************
  mrb_feature_t feature_reg;
  logic [1:0] selfTest_reg;
  mrb_state_t state_reg;
  mrb_state_t state_next;
  logic [COL_W-1:0] start_reg;
  logic [3:0] beat_reg;
  logic [3:0] recCnt_reg;
  logic apWrite_reg;
  logic [7:0] rdData_reg;
  logic rdStrobe_reg;
  logic calRun_reg;
  logic factoryTrim_reg;
  logic [COL_W-1:0] colOut_reg;
  logic colValid_reg;
  logic precharge_reg;

  // ***************************************************
  // decode
  // ***************************************************
  mrb_info_t infoValue;
  wire logic hitInfo = (mrAddr == INFO_REG_ADDR);
  wire logic hitFeature = (mrAddr == FEATURE_REG_ADDR);
  wire logic accepted = burstReq && (state_reg == BST_IDLE);
  wire logic [3:0] nwrCycles = {1'b0, feature_reg.writeRecovery} + NWR_CODE_OFFSET;
  wire logic [COL_W-1:0] evenStart = {burstCol[COL_W-1:1], 1'b0};
  wire logic [3:0] beatNext = beat_reg + 4'h1;
  wire logic [3:0] lastBeat = (feature_reg.burstLength == BL_CODE_16) ? LAST_BEAT_16 :
                              (feature_reg.burstLength == BL_CODE_8) ? LAST_BEAT_8 :
                              LAST_BEAT_4;
  wire logic atLast = (beat_reg == lastBeat);
  wire logic trimForced = (selfTest_reg == ST_SUPPLY_OR_FLOAT) || (selfTest_reg == ST_SHORT_GND);
  wire logic [1:0] selfTestNew = pinTiedSupply ? ST_SUPPLY_OR_FLOAT : calResult;

  assign infoValue = '{reservedBits: INFO_RSVD_BITS, selfTest: selfTest_reg,
    invalidDataSupport: CLASS_BITS[1], deviceClass: CLASS_BITS[0], autoInitBusy: !autoInitDone};

  wire logic [7:0] readValue = hitInfo ? infoValue : UNDEF_READ_DATA;

  function automatic logic [COL_W-1:0] beatCol(input logic [COL_W-1:0] s,
                                               input logic [3:0] i,
                                               input mrb_feature_t f);
    logic [COL_W-1:0] c;
    c = s;
    if (f.burstLength == BL_CODE_16)
      c[3:0] = s[3:0] + i;
    else if (f.burstLength == BL_CODE_8)
      c[2:0] = f.interleaved ? (s[2:0] ^ i[2:0]) : (s[2:0] + i[2:0]);
    else if (f.noWrap)
      c = s + COL_W'(i);
    else
      c[1:0] = s[1:0] + i[1:0];
    return c;
  endfunction : beatCol

  wire logic [COL_W-1:0] nextCol = beatCol(start_reg, beatNext, feature_reg);

  // ***************************************************
  // burst state machine
  // ***************************************************
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      BST_IDLE:
        if (accepted)
          state_next = BST_BEATS;
      BST_BEATS:
        if (atLast)
          state_next = apWrite_reg ? BST_RECOVER : BST_IDLE;
      BST_RECOVER:
        if (recCnt_reg == 4'h0)
          state_next = BST_IDLE;
      default:
        state_next = BST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= BST_IDLE;
      start_reg <= '0;
      beat_reg <= 4'h0;
      apWrite_reg <= 1'b0;
      colOut_reg <= '0;
      colValid_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      colValid_reg <= accepted || (state_reg == BST_BEATS && !atLast);
      if (accepted)
      begin
        start_reg <= evenStart;
        beat_reg <= 4'h0;
        apWrite_reg <= burstWrite && burstAutoPre;
        colOut_reg <= evenStart;
      end
      else if (state_reg == BST_BEATS && !atLast)
      begin
        beat_reg <= beatNext;
        colOut_reg <= nextCol;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      recCnt_reg <= 4'h0;
      precharge_reg <= 1'b0;
    end
    else
    begin
      precharge_reg <= (state_reg == BST_RECOVER) && (recCnt_reg == 4'h0);
      if (state_reg == BST_BEATS)
        recCnt_reg <= nwrCycles - 4'h1;
      else if (state_reg == BST_RECOVER)
        recCnt_reg <= recCnt_reg - 4'h1;
    end
  end

  // ***************************************************
  // mode registers
  // ***************************************************
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      feature_reg <= FEATURE_RESET;
      selfTest_reg <= ST_NOT_RUN;
      rdData_reg <= 8'h00;
      rdStrobe_reg <= 1'b0;
      calRun_reg <= 1'b0;
      factoryTrim_reg <= 1'b0;
    end
    else
    begin
      if (mrWrite && hitFeature)
        feature_reg <= mrWdata;
      if (calDone)
        selfTest_reg <= selfTestNew;
      rdStrobe_reg <= mrRead;
      if (mrRead)
        rdData_reg <= readValue;
      factoryTrim_reg <= trimForced;
      calRun_reg <= calCmd && !trimForced;
    end
  end

  assign rdData = rdData_reg;
  assign rdStrobe = rdStrobe_reg;
  assign calRun = calRun_reg;
  assign factoryTrim = factoryTrim_reg;
  assign colOut = colOut_reg;
  assign colValid = colValid_reg;
  assign prechargeStart = precharge_reg;
  // gray codes leave bit 0 set in every non-idle state, so busy is a flop
  assign busy = state_reg[0];

  // ***************************************************
  // checks
  // ***************************************************
  logic [3:0] recSeen_reg;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      recSeen_reg <= 4'h0;
    else if (state_reg == BST_RECOVER)
      recSeen_reg <= recSeen_reg + 4'h1;
    else
      recSeen_reg <= 4'h0;
  end

  sequence s_infoRead;
    mrRead && hitInfo;
  endsequence
  sequence s_writeApEnd;
    state_reg == BST_BEATS && atLast && apWrite_reg;
  endsequence
  a_init_bit_read: assert property (@(posedge clock) disable iff (!nrst)
    s_infoRead |=> rdData[0] == !$past(autoInitDone))
    else $error("auto-init bit wrong");
  a_class_bits_zero: assert property (@(posedge clock) disable iff (!nrst)
    s_infoRead |=> rdStrobe && rdData[2:1] == 2'h0)
    else $error("class bits not zero");
  a_reserved_read_zero: assert property (@(posedge clock) disable iff (!nrst)
    s_infoRead |=> rdData[7:5] == 3'h0 && rdData[4:3] == $past(selfTest_reg))
    else $error("info reserved or self-test bits wrong");
  a_selftest_update: assert property (@(posedge clock) disable iff (!nrst)
    calDone |=> selfTest_reg == $past(selfTestNew))
    else $error("self-test not updated");
  a_tied_pin_code: assert property (@(posedge clock) disable iff (!nrst)
    calDone && pinTiedSupply |=> selfTest_reg == ST_SUPPLY_OR_FLOAT)
    else $error("tied pin code wrong");
  a_cal_ignored: assert property (@(posedge clock) disable iff (!nrst)
    calCmd && trimForced |=> !calRun && factoryTrim)
    else $error("calibration not ignored");
  a_feature_latch: assert property (@(posedge clock) disable iff (!nrst)
    mrWrite && hitFeature |=> feature_reg == $past(mrWdata))
    else $error("feature not latched");
  a_info_write_ignored: assert property (@(posedge clock) disable iff (!nrst)
    mrWrite && hitInfo |=> $stable(feature_reg))
    else $error("info write changed state");
  a_even_start_col: assert property (@(posedge clock) disable iff (!nrst)
    accepted |=> colValid && colOut[0] == 1'b0)
    else $error("burst start not even");
  a_recovery_cycles: assert property (@(posedge clock) disable iff (!nrst)
    s_writeApEnd ##1 (state_reg == BST_RECOVER) |-> ##[0:8] (recCnt_reg == 4'h0)
      ##1 prechargeStart && recSeen_reg == nwrCycles)
    else $error("precharge timing wrong");
  a_bl4_wrap_order: assert property (@(posedge clock) disable iff (!nrst)
    accepted && feature_reg.burstLength == BL_CODE_4 && !feature_reg.noWrap
      |=> ##2 colValid && colOut[1:0] == ($past(evenStart[1:0], 3) ^ 2'h2))
    else $error("4-beat wrap order wrong");
endmodule : mrb_mode_burst

// ==== include/mrb_pkg.sv ====
// constants, field layouts and carrier types for the mode register and burst block
package mrb_pkg;

  // ***************************************************
  // register addresses
  // ***************************************************
  localparam logic [7:0] INFO_REG_ADDR = 8'h00;
  localparam logic [7:0] FEATURE_REG_ADDR = 8'h01;
  // data returned for a register that cannot be read
  localparam logic [7:0] UNDEF_READ_DATA = 8'hFF;

  // ***************************************************
  // field codes and reset values
  // ***************************************************
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] BL_CODE_16 = 3'h4;
  localparam logic [1:0] ST_NOT_RUN = 2'h0;
  localparam logic [1:0] ST_SUPPLY_OR_FLOAT = 2'h1;
  localparam logic [1:0] ST_SHORT_GND = 2'h2;
  localparam logic [1:0] ST_PASS = 2'h3;
  localparam logic [3:0] NWR_CODE_OFFSET = 4'h2;
  localparam logic [3:0] LAST_BEAT_4 = 4'h3;
  localparam logic [3:0] LAST_BEAT_8 = 4'h7;
  localparam logic [3:0] LAST_BEAT_16 = 4'hF;
  localparam logic [1:0] CLASS_BITS = 2'h0;
  localparam logic [2:0] INFO_RSVD_BITS = 3'h0;

  // ***************************************************
  // carrier types
  // ***************************************************
  typedef struct packed {
    logic [2:0] writeRecovery;
    logic noWrap;
    logic interleaved;
    logic [2:0] burstLength;
  } mrb_feature_t;

  localparam mrb_feature_t FEATURE_RESET = '{writeRecovery: 3'h1, noWrap: 1'b0,
    interleaved: 1'b0, burstLength: BL_CODE_4};

  typedef struct packed {
    logic [2:0] reservedBits;
    logic [1:0] selfTest;
    logic invalidDataSupport;
    logic deviceClass;
    logic autoInitBusy;
  } mrb_info_t;

  typedef enum logic [1:0] {
    BST_IDLE = 2'b00,
    BST_BEATS = 2'b01,
    BST_RECOVER = 2'b11
  } mrb_state_t;

endpackage : mrb_pkg
